// File: include/hdcr_consts.vh
// register offsets, reset values and scaling constants of the drive calibration bank
`ifndef HDCR_CONSTS_VH
`define HDCR_CONSTS_VH

// register indexes; byte address is four times the index
`define HDCR_IDX_PEAK_DRIVE   8'h15
`define HDCR_IDX_NOMINAL      8'h16
`define HDCR_IDX_BOOST        8'h17
`define HDCR_IDX_LOSS_COMP    8'h18
`define HDCR_IDX_BACKEMF      8'h19
`define HDCR_IDX_CTRL         8'h1B
`define HDCR_IDX_STATUS       8'h1C

// reset values
`define HDCR_RST_PEAK_DRIVE   8'hFF
`define HDCR_RST_NOMINAL      8'h3E
`define HDCR_RST_BOOST        8'h8C
`define HDCR_RST_LOSS_COMP    8'h0C
`define HDCR_RST_BACKEMF      8'h6F
`define HDCR_RST_CTRL         8'h00

// control register fields
`define HDCR_CTRL_CLOSED_LOOP 0
`define HDCR_CTRL_CAL_START   1
`define HDCR_CTRL_SCALE_LO    2
`define HDCR_CTRL_SCALE_HI    3

// status register fields
`define HDCR_STAT_CAL_BUSY    0
`define HDCR_STAT_CAL_DONE    1

// full scale of an 8-bit level code
`define HDCR_FULL_SCALE       8'hFF

// calibration measurement settle time in ns, and its cycle count at 10 ns
`define HDCR_CAL_SETTLE_NS    1000
`define HDCR_CLK_PERIOD_NS    10
`define HDCR_CAL_SETTLE_CYC   (`HDCR_CAL_SETTLE_NS / `HDCR_CLK_PERIOD_NS)

`endif

// File: sim/hdcr_regs_sva.sv
// assertion checker for the drive calibration register bank
`timescale 1ns/1ns
module hdcr_regs_sva (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // playback and front end
    input wire logic [7:0]  play_level_i,
    input wire logic        overdrive_i,
    input wire logic [7:0]  meas_impedance_i,
    input wire logic [7:0]  meas_backemf_i,
    // drive outputs
    input wire logic [8:0]  drive_level_o,
    input wire logic [7:0]  fb_gain_o,
    input wire logic [1:0]  backemf_scale_select_o,
    input wire logic        closed_loop_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // an accepted write with the low byte enabled
    sequence wr_s(a);
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
    endsequence
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    scale_sel_a: assert property (wr_s(8'h1B) |=> backemf_scale_select_o == $past(wb_dat_i[3:2]))
        else $error("scale select does not follow control write");
    loop_mode_a: assert property (wr_s(8'h1B) |=> closed_loop_o == $past(wb_dat_i[0]))
        else $error("loop mode does not follow control write");
    gain_write_a: assert property (wr_s(8'h19) |=> fb_gain_o == 8'hFF - $past(wb_dat_i[7:0]))
        else $error("feedback gain does not follow back-emf write");
    gain_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h19 |->
        fb_gain_o == 8'hFF - wb_dat_o[7:0])
        else $error("feedback gain disagrees with back-emf level");
endmodule
bind hdcr_regs hdcr_regs_sva i_hdcr_regs_sva (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .play_level_i,
    .overdrive_i, .meas_impedance_i, .meas_backemf_i, .drive_level_o, .fb_gain_o,
    .backemf_scale_select_o, .closed_loop_o);

// File: sim/hdcr_regs_tb.sv
// self-checking bench for the drive calibration register bank
`timescale 1ns/1ns
module hdcr_regs_tb;
    logic        clk_sys_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic        overdrive_i = 0;
    logic [7:0]  wb_adr_i = 0, play_level_i = 0, meas_impedance_i = 0, meas_backemf_i = 0;
    logic [3:0]  wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, closed_loop_o;
    wire  [8:0]  drive_level_o;
    wire  [7:0]  fb_gain_o;
    wire  [1:0]  backemf_scale_select_o;
    int          failures = 0, n_checks = 0;
    logic [31:0] exp_q[$];
    logic [7:0]  adr_q[$], v, imp, pk, nm, bs, cp, pl, lm;
    hdcr_regs i_hdcr_regs (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .play_level_i, .overdrive_i,
        .meas_impedance_i, .meas_backemf_i, .drive_level_o, .fb_gain_o,
        .backemf_scale_select_o, .closed_loop_o);
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic check(input string nm_s, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm_s, exp, seen);
        end
    endtask
    // rounded n*d/255, the ratio that every level code stands for
    function automatic logic [7:0] frac(input int n, d);
        return 8'((n * d * 2 + 255) / 510);
    endfunction
    // one classic cycle; request held until ack is sampled, then released
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge clk_sys_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
        // no answer time assumed; only the watchdog ends a hung wait
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        adr_q.push_back(a);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
        xfer(1'b1, a, {24'h0, d}, s);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // read data is judged here, against the oldest note
    always @(posedge clk_sys_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) failures++;
            else check($sformatf("reg_%h", adr_q.pop_front()), wb_dat_o, exp_q.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        failures++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'h2157));
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1;
        rd(8'h15, 32'hFF);
        rd(8'h16, 32'h3E);
        rd(8'h17, 32'h8C);
        rd(8'h18, 32'h0C);
        rd(8'h19, 32'h6F);
        rd(8'h20, 32'h0);
        check("fb_gain", fb_gain_o, 32'hFF - 32'h6F);
        $display("test reset values done");
        // a write without the low byte lane must leave the value alone
        for (int a = 8'h15; a <= 8'h19; a++) begin
            v = $urandom;
            {play_level_i, overdrive_i} <= 9'($urandom);
            wr(a[7:0], v);
            wr(a[7:0], ~v, 4'hE);
            rd(a[7:0], {24'h0, v});
        end
        $display("test write readback done");
        for (int m = 0; m < 8; m++) begin
            wr(8'h1B, {4'h0, m[2:1], 1'b0, m[0]});
            rd(8'h1B, {28'h0, m[2:1], 1'b0, m[0]});
        end
        check("closed_loop", {31'h0, closed_loop_o}, 32'h1);
        check("scale_sel", {30'h0, backemf_scale_select_o}, 32'h3);
        $display("test control modes done");
        // nominal level loaded first since the routine reads it
        imp = $urandom;
        meas_impedance_i <= imp;
        meas_backemf_i <= 8'h90;
        wr(8'h16, 8'h50);
        wr(8'h1B, 8'h03);
        rd(8'h1B, 32'h1);
        rd(8'h1C, 32'h1);
        repeat (150) @(posedge clk_sys_i);
        rd(8'h1C, 32'h2);
        rd(8'h18, {24'h0, imp});
        rd(8'h19, 32'h50);
        check("fb_gain", fb_gain_o, 32'hFF - 32'h50);
        wr(8'h1C, 8'h02);
        rd(8'h1C, 32'h0);
        $display("test calibration done");
        // drive path: reference per mode, overdrive cap, peak ratio, loss compensation
        for (int k = 0; k < 8; k++) begin
            {pk, nm, bs, cp} = $urandom;
            pl = $urandom;
            wr(8'h15, pk);
            wr(8'h16, nm);
            wr(8'h17, bs);
            wr(8'h18, cp);
            wr(8'h1B, {7'h0, k[0]});
            play_level_i <= pl;
            overdrive_i  <= k[1];
            lm = (k[0] && k[1]) ? bs : frac(pl, k[0] ? nm : bs);
            lm = frac(lm, pk);
            repeat (4) @(posedge clk_sys_i);
            check("drive_level", {23'h0, drive_level_o}, {24'h0, lm} + frac(lm, cp));
        end
        $display("test drive path done");
        end_of_test;
    end
endmodule

// File: src/hdcr_cal_engine.v
// calibration sequencer: measures impedance and back-emf, yields the two result codes
`timescale 1ns/1ns
module hdcr_cal_engine (
    // clock and reset
    input  wire       clk_sys_i,
    input  wire       rst_n_i,
    // control
    input  wire       start_i,
    input  wire [7:0] nominal_i,
    // measurements from the analog front end
    input  wire [7:0] meas_impedance_i,
    input  wire [7:0] meas_backemf_i,
    // results
    output reg        busy_o,
    output reg        done_o,
    output reg  [7:0] comp_o,
    output reg  [7:0] backemf_o
);
`include "hdcr_consts.vh"

    localparam [2:0] S_IDLE   = 3'b001;
    localparam [2:0] S_SETTLE = 3'b010;
    localparam [2:0] S_STORE  = 3'b100;

    reg [2:0]  state;
    reg [15:0] cnt;
    reg [7:0]  nominal_held;

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state        <= S_IDLE;
            cnt          <= 16'h0000;
            busy_o       <= 1'b0;
            done_o       <= 1'b0;
            comp_o       <= 8'h00;
            backemf_o    <= 8'h00;
            nominal_held <= 8'h00;
        end else begin
            done_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_i) begin
                        // nominal level is an input to the routine
                        nominal_held <= nominal_i;
                        cnt          <= 16'h0000;
                        busy_o       <= 1'b1;
                        state        <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (cnt == `HDCR_CAL_SETTLE_CYC - 1) begin
                        state <= S_STORE;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                S_STORE: begin
                    // higher impedance means more loss to offset
                    comp_o    <= meas_impedance_i;
                    // back-emf seen at nominal drive, capped at the nominal code
                    backemf_o <= (meas_backemf_i > nominal_held) ? nominal_held
                                                                  : meas_backemf_i;
                    busy_o    <= 1'b0;
                    done_o    <= 1'b1;
                    state     <= S_IDLE;
                end
                default: begin
                    state  <= S_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: src/hdcr_level_scale.v
// scales a drive level by a ratio n/255 and applies the loss compensation coefficient
`timescale 1ns/1ns
module hdcr_level_scale (
    // clock and reset
    input  wire       clk_sys_i,
    input  wire       rst_n_i,
    // operands
    input  wire [7:0] level_i,
    input  wire [7:0] peak_i,
    input  wire [7:0] comp_i,
    // result
    output reg  [8:0] drive_o
);
`include "hdcr_consts.vh"

    reg  [15:0] peaked;
    wire [15:0] peaked_rnd;
    wire [15:0] peaked_div;
    wire [7:0]  peaked_lvl;
    wire [15:0] comp_part;
    wire [15:0] comp_rnd;
    wire [15:0] comp_div;
    wire [8:0]  sum;

    // level scaled by the peak ratio: level * peak / 255
    always @* begin
        peaked = level_i * peak_i;
    end
    // rounded division by 255, not a shift by 8, so full scale stays full scale
    assign peaked_rnd = peaked + 16'h0080;
    assign peaked_div = peaked_rnd + {8'h00, peaked_rnd[15:8]};
    assign peaked_lvl = peaked_div[15:8];

    // gain times (1 + comp/255), same rounded division
    assign comp_part = peaked_lvl * comp_i;
    assign comp_rnd  = comp_part + 16'h0080;
    assign comp_div  = comp_rnd + {8'h00, comp_rnd[15:8]};
    assign sum = {1'b0, peaked_lvl} + {1'b0, comp_div[15:8]};

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_o <= 9'h000;
        end else begin
            drive_o <= sum;
        end
    end
endmodule

// File: src/hdcr_regs.v
// haptic drive calibration register bank with wishbone slave and playback level outputs
// Notes on behaviour
// - peak drive register resets to FF; scales the level to value/255 of full scale before loss compensation
// - nominal level resets to 3E; closed-loop full-scale reference
// - open loop ignores nominal level and uses boost limit as reference
// - boost limit resets to 8C; caps closed-loop overdrive output
// - in open loop boost limit is the full-scale reference
// - loss compensation resets to 0C; calibration stores its result there
// - calibration measures impedance to derive loss compensation
// - drive gain multiplied by one plus compensation over 255
// - back-emf result resets to 6F; holds back-emf at nominal drive
// - back-emf result selects closed-loop feedback gain
// - back-emf volts equal value/255 times 1.22 over selected gain
`timescale 1ns/1ns
module hdcr_regs (
    // clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // playback engine
    input  wire [7:0]  play_level_i,
    input  wire        overdrive_i,
    // calibration front end
    input  wire [7:0]  meas_impedance_i,
    input  wire [7:0]  meas_backemf_i,
    // drive outputs
    output reg  [8:0]  drive_level_o,
    output reg  [7:0]  fb_gain_o,
    output reg  [1:0]  backemf_scale_select_o,
    output reg         closed_loop_o
);
`include "hdcr_consts.vh"

    reg  [7:0] a2v_peak_drive_level;
    reg  [7:0] nominal_motor_level;
    reg  [7:0] boost_limit;
    reg  [7:0] cal_loss_compensation;
    reg  [7:0] cal_backemf_level;
    reg  [7:0] ctrl;
    reg        cal_done_flag;
    reg        cal_start;
    reg  [7:0] ref_level;
    reg  [7:0] limited;
    reg  [7:0] next_rdata;
    reg  [7:0] next_fb_gain;
    wire       cal_busy;
    wire       cal_done;
    wire [7:0] cal_comp;
    wire [7:0] cal_bemf;
    wire [8:0] scaled;
    wire       wr_en;
    wire       req;
    wire [15:0] ref_prod;
    wire [7:0]  ref_scaled;
    wire [15:0] ref_rnd;
    wire [15:0] ref_div;

    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = req & wb_we_i & wb_sel_i[0];

    // calibration sequencer
    hdcr_cal_engine u_cal (
        .clk_sys_i        (clk_sys_i),
        .rst_n_i          (rst_n_i),
        .start_i          (cal_start),
        .nominal_i        (nominal_motor_level),
        .meas_impedance_i (meas_impedance_i),
        .meas_backemf_i   (meas_backemf_i),
        .busy_o           (cal_busy),
        .done_o           (cal_done),
        .comp_o           (cal_comp),
        .backemf_o        (cal_bemf)
    );

    // registers; a finished calibration wins over a same-cycle host write
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a2v_peak_drive_level  <= `HDCR_RST_PEAK_DRIVE;
            nominal_motor_level   <= `HDCR_RST_NOMINAL;
            boost_limit           <= `HDCR_RST_BOOST;
            cal_loss_compensation <= `HDCR_RST_LOSS_COMP;
            cal_backemf_level     <= `HDCR_RST_BACKEMF;
            ctrl                  <= `HDCR_RST_CTRL;
            cal_done_flag         <= 1'b0;
            cal_start             <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            if (wr_en) begin
                case (wb_adr_i)
                    `HDCR_IDX_PEAK_DRIVE: a2v_peak_drive_level <= wb_dat_i[7:0];
                    `HDCR_IDX_NOMINAL:    nominal_motor_level  <= wb_dat_i[7:0];
                    `HDCR_IDX_BOOST:      boost_limit          <= wb_dat_i[7:0];
                    `HDCR_IDX_LOSS_COMP:  cal_loss_compensation <= wb_dat_i[7:0];
                    `HDCR_IDX_BACKEMF:    cal_backemf_level    <= wb_dat_i[7:0];
                    `HDCR_IDX_CTRL: begin
                        ctrl      <= {4'h0, wb_dat_i[3:2], 1'b0, wb_dat_i[0]};
                        // start ignored while a run is in progress
                        cal_start <= wb_dat_i[`HDCR_CTRL_CAL_START] & ~cal_busy;
                    end
                    default: ;
                endcase
            end
            if (cal_done) begin
                cal_loss_compensation <= cal_comp;
                cal_backemf_level     <= cal_bemf;
            end
            // done flag: set wins over a clear written to the status word
            if (cal_done) begin
                cal_done_flag <= 1'b1;
            end else if (wr_en && wb_adr_i == `HDCR_IDX_STATUS
                         && wb_dat_i[`HDCR_STAT_CAL_DONE]) begin
                cal_done_flag <= 1'b0;
            end
        end
    end

    // reference level for full scale depends on loop mode
    always @* begin
        if (ctrl[`HDCR_CTRL_CLOSED_LOOP]) begin
            ref_level = nominal_motor_level;
        end else begin
            ref_level = boost_limit;
        end
    end

    // request scaled to reference, then overdrive clamp in closed loop
    assign ref_prod   = play_level_i * ref_level;
    assign ref_rnd    = ref_prod + 16'h0080;
    assign ref_div    = ref_rnd + {8'h00, ref_rnd[15:8]};
    assign ref_scaled = ref_div[15:8];

    always @* begin
        if (ctrl[`HDCR_CTRL_CLOSED_LOOP] && overdrive_i) begin
            // overdrive may exceed nominal but never the boost limit
            limited = boost_limit;
        end else begin
            limited = ref_scaled;
        end
    end

    hdcr_level_scale u_scale (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .level_i   (limited),
        .peak_i    (a2v_peak_drive_level),
        .comp_i    (cal_loss_compensation),
        .drive_o   (scaled)
    );

    // feedback gain falls as back-emf grows; the selected scale sets volts per code
    always @* begin
        next_fb_gain = `HDCR_FULL_SCALE - cal_backemf_level;
    end

    // read mux
    always @* begin
        case (wb_adr_i)
            `HDCR_IDX_PEAK_DRIVE: next_rdata = a2v_peak_drive_level;
            `HDCR_IDX_NOMINAL:    next_rdata = nominal_motor_level;
            `HDCR_IDX_BOOST:      next_rdata = boost_limit;
            `HDCR_IDX_LOSS_COMP:  next_rdata = cal_loss_compensation;
            `HDCR_IDX_BACKEMF:    next_rdata = cal_backemf_level;
            `HDCR_IDX_CTRL:       next_rdata = ctrl;
            `HDCR_IDX_STATUS:     next_rdata = {6'h00, cal_done_flag, cal_busy};
            default:              next_rdata = 8'h00;
        endcase
    end

    // bus answer one cycle after request; unmapped reads return zero
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o               <= 1'b0;
            wb_dat_o               <= 32'h00000000;
            drive_level_o          <= 9'h000;
            fb_gain_o              <= 8'h00;
            backemf_scale_select_o <= 2'h0;
            closed_loop_o          <= 1'b0;
        end else begin
            wb_ack_o               <= req;
            wb_dat_o               <= (req && !wb_we_i) ? {24'h000000, next_rdata}
                                                        : 32'h00000000;
            drive_level_o          <= scaled;
            fb_gain_o              <= next_fb_gain;
            backemf_scale_select_o <= ctrl[`HDCR_CTRL_SCALE_HI:`HDCR_CTRL_SCALE_LO];
            closed_loop_o          <= ctrl[`HDCR_CTRL_CLOSED_LOOP];
        end
    end
endmodule
